// ===== hdl/adc_ctrl_pkg.sv
// Package for the ADC overflow and gain control register bank.
// Assumes a single 20 MHz clock and a plain register port.
package adc_ctrl_pkg;
    localparam logic [7:0] OVERFLOW_STATUS_OFFSET = 8'h56;
    localparam logic [7:0] CONTROL_THREE_OFFSET = 8'h57;
    localparam logic [7:0] GAIN_LEVEL_BASE_OFFSET = 8'h58;
    localparam logic [7:0] GAIN_LEVEL_LAST_OFFSET = 8'h5e;
    localparam logic [7:0] IRQ_MASK_OFFSET = 8'h60;
    localparam int CHANNELS = 6;
    localparam int MODE_SELECT_BIT = 7;
    localparam int RAMP_SPEED_BIT = 6;
    localparam int PIN_POLARITY_BIT = 0;
    localparam logic [7:0] CONTROL_THREE_RESET = 8'h00;
    localparam logic [7:0] CONTROL_THREE_MASK = 8'hc1;
    localparam logic [7:0] GAIN_LEVEL_RESET = 8'hd7;
    localparam logic [7:0] GAIN_UNITY_CODE = 8'hd7;
    localparam logic [7:0] GAIN_MUTE_LAST = 8'h0e;
    localparam logic [7:0] GAIN_MAX_CODE = 8'hff;
    localparam int RAMP_BASE_SAMPLES = 2048;
    localparam int RAMP_SLOW_SAMPLES = 4096;
endpackage : adc_ctrl_pkg

// ===== hdl/adc_overflow_gain_ctrl.sv
// Overflow flags, gain mode and ramp control registers of a six-channel ADC.
// Assumes a synchronous register port and overflow pulses from the converters.
`timescale 1ns/100ps
module adc_overflow_gain_ctrl
    import adc_ctrl_pkg::*;
#(
    parameter int NUM_CHANNELS = CHANNELS
)
(
    // Clock and reset.
    input wire logic CLK,
    input wire logic RST,
    // Register port.
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    // Converter side.
    input wire logic [NUM_CHANNELS-1:0] OVERFLOW_DETECT,
    input wire logic SAMPLE_TICK,
    input wire logic ADC_SAMPLE_RATE_MODE,
    output logic [8*NUM_CHANNELS-1:0] ADC_CHANNEL_GAIN_LEVEL,
    output logic [NUM_CHANNELS-1:0] RAMP_BUSY,
    // Pins.
    output logic OVERFLOW_PIN,
    output logic IRQ
);
    if (NUM_CHANNELS != CHANNELS) begin : bad_channel_count
        $error("Channel count must be six.");
    end

    logic [5:0] channel_overflow_flags;
    logic [5:0] next_flags;
    logic [7:0] control_three;
    logic [7:0] next_control_three;
    logic [5:0] irq_mask;
    logic [5:0] next_irq_mask;
    logic [7:0] gain_code [0:6];
    logic [7:0] next_gain_code [0:6];
    logic [7:0] next_rdata;
    logic [13:0] ramp_samples;
    logic adc_gain_mode_select;
    logic adc_gain_ramp_speed;
    logic overflow_pin_polarity;

    assign adc_gain_mode_select = control_three[MODE_SELECT_BIT];
    assign adc_gain_ramp_speed = control_three[RAMP_SPEED_BIT];
    assign overflow_pin_polarity = control_three[PIN_POLARITY_BIT];

    function automatic logic is_gain_addr(input logic [7:0] a);
        is_gain_addr = (a >= GAIN_LEVEL_BASE_OFFSET) && (a <= GAIN_LEVEL_LAST_OFFSET);
    endfunction : is_gain_addr

    always_comb begin
        next_flags = channel_overflow_flags;
        next_control_three = control_three;
        next_irq_mask = irq_mask;
        for (int i = 0; i < 7; i++) begin
            next_gain_code[i] = gain_code[i];
        end
        next_rdata = 8'h00;
        if (RD && ADDR == OVERFLOW_STATUS_OFFSET) begin
            next_flags = 6'h00;
        end
        next_flags = next_flags | OVERFLOW_DETECT;
        if (WR) begin
            if (ADDR == CONTROL_THREE_OFFSET) begin
                next_control_three = WDATA & CONTROL_THREE_MASK;
            end else if (ADDR == IRQ_MASK_OFFSET) begin
                next_irq_mask = WDATA[5:0];
            end else if (is_gain_addr(ADDR)) begin
                next_gain_code[3'(ADDR - GAIN_LEVEL_BASE_OFFSET)] = WDATA;
            end
        end
        if (RD) begin
            if (ADDR == OVERFLOW_STATUS_OFFSET) begin
                next_rdata = {2'b00, channel_overflow_flags};
            end else if (ADDR == CONTROL_THREE_OFFSET) begin
                next_rdata = control_three;
            end else if (ADDR == IRQ_MASK_OFFSET) begin
                next_rdata = {2'b00, irq_mask};
            end else if (is_gain_addr(ADDR)) begin
                next_rdata = gain_code[3'(ADDR - GAIN_LEVEL_BASE_OFFSET)];
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            channel_overflow_flags <= 6'h00;
            control_three <= CONTROL_THREE_RESET;
            irq_mask <= 6'h00;
            RDATA <= 8'h00;
            for (int i = 0; i < 7; i++) begin
                gain_code[i] <= GAIN_LEVEL_RESET;
            end
        end else begin
            channel_overflow_flags <= next_flags;
            control_three <= next_control_three;
            irq_mask <= next_irq_mask;
            RDATA <= next_rdata;
            for (int i = 0; i < 7; i++) begin
                gain_code[i] <= next_gain_code[i];
            end
        end
    end

    assign OVERFLOW_PIN = (|channel_overflow_flags) ^ overflow_pin_polarity;
    assign IRQ = |(channel_overflow_flags & irq_mask);

    always_comb begin
        ramp_samples = adc_gain_ramp_speed ? 14'(RAMP_SLOW_SAMPLES) : 14'(RAMP_BASE_SAMPLES);
        if (ADC_SAMPLE_RATE_MODE) begin
            ramp_samples = ramp_samples << 1;
        end
    end

    for (genvar c = 0; c < 6; c++) begin : channel
        logic [7:0] target;
        // Preset code passes unchanged to the ramp while mode select is clear; when set, it is combined with the master.
        gain_combiner combine (
            .mode_select(adc_gain_mode_select),
            .master_code(gain_code[0]),
            .preset_code(gain_code[c+1]),
            .effective_code(target)
        );
        gain_ramp ramp (
            .clk(CLK),
            .rst(RST),
            .sample_tick(SAMPLE_TICK),
            .ramp_samples(ramp_samples),
            .target_code(target),
            .level(ADC_CHANNEL_GAIN_LEVEL[8*c+:8]),
            .busy(RAMP_BUSY[c])
        );

        a_own_level: assert property (@(posedge CLK) disable iff (RST)
            !adc_gain_mode_select |-> target == gain_code[c+1])
            else $error("Channel ignores its own level.");

        a_unity_master: assert property (@(posedge CLK) disable iff (RST)
            (adc_gain_mode_select && gain_code[0] == GAIN_UNITY_CODE && gain_code[c+1] > GAIN_MUTE_LAST)
            |-> target == gain_code[c+1])
            else $error("Unity master changed the level.");

        a_master_mute: assert property (@(posedge CLK) disable iff (RST)
            (adc_gain_mode_select && (gain_code[0] <= GAIN_MUTE_LAST || gain_code[c+1] <= GAIN_MUTE_LAST))
            |-> target == 8'h00)
            else $error("Mute code did not mute.");

        a_clamp_top: assert property (@(posedge CLK) disable iff (RST)
            (adc_gain_mode_select && gain_code[0] == GAIN_MAX_CODE && gain_code[c+1] >= GAIN_UNITY_CODE)
            |-> target == GAIN_MAX_CODE)
            else $error("Summed level above the top code.");

        a_level_steps: assert property (@(posedge CLK) disable iff (RST)
            !(RAMP_BUSY[c] && SAMPLE_TICK) |=> $stable(ADC_CHANNEL_GAIN_LEVEL[8*c+:8]))
            else $error("Level moved outside a ramp end.");

        a_ramp_starts: assert property (@(posedge CLK) disable iff (RST)
            (!RAMP_BUSY[c] && target != ADC_CHANNEL_GAIN_LEVEL[8*c+:8]) |=> RAMP_BUSY[c])
            else $error("Pending command not started.");

        a_ramp_needs_tick: assert property (@(posedge CLK) disable iff (RST)
            (RAMP_BUSY[c] && !SAMPLE_TICK) |=> RAMP_BUSY[c])
            else $error("Ramp ended without a sample tick.");

        a_ramp_minimum: assert property (@(posedge CLK) disable iff (RST)
            $rose(RAMP_BUSY[c]) |-> RAMP_BUSY[c] [*8])
            else $error("Ramp ended too soon.");
    end

    sequence s_status_read;
        RD && ADDR == OVERFLOW_STATUS_OFFSET && OVERFLOW_DETECT == 6'h00;
    endsequence

    sequence s_clearing_read;
        RD && ADDR == OVERFLOW_STATUS_OFFSET;
    endsequence

    sequence s_status_write;
        WR && ADDR == OVERFLOW_STATUS_OFFSET;
    endsequence

    sequence s_control_write;
        WR && ADDR == CONTROL_THREE_OFFSET;
    endsequence

    a_read_clears_flags: assert property (@(posedge CLK) disable iff (RST)
        s_status_read |=> channel_overflow_flags == 6'h00)
        else $error("Flags not cleared by read.");
    a_flag_stays_set: assert property (@(posedge CLK) disable iff (RST)
        (channel_overflow_flags[0] && !(RD && ADDR == OVERFLOW_STATUS_OFFSET)) |=> channel_overflow_flags[0])
        else $error("Flag dropped without read.");
    a_set_beats_clear: assert property (@(posedge CLK) disable iff (RST)
        (OVERFLOW_DETECT[5] && RD) |=> channel_overflow_flags[5])
        else $error("Overflow lost on clearing read.");
    a_read_data_flags: assert property (@(posedge CLK) disable iff (RST)
        (RD && ADDR == OVERFLOW_STATUS_OFFSET) |=> RDATA == {2'b00, $past(channel_overflow_flags)})
        else $error("Status read data wrong.");
    a_status_write_ignored: assert property (@(posedge CLK) disable iff (RST)
        (WR && ADDR == OVERFLOW_STATUS_OFFSET && !RD && OVERFLOW_DETECT == 6'h00)
        |=> channel_overflow_flags == $past(channel_overflow_flags))
        else $error("Status write took effect.");
    a_pin_polarity: assert property (@(posedge CLK) disable iff (RST)
        (channel_overflow_flags != 6'h00) |-> OVERFLOW_PIN == !control_three[0])
        else $error("Overflow pin level wrong.");
    a_ramp_length: assert property (@(posedge CLK) disable iff (RST)
        (ADC_SAMPLE_RATE_MODE && !control_three[6]) |-> ramp_samples == 14'h1000)
        else $error("Dual rate ramp length wrong.");
    a_independent_mode: assert property (@(posedge CLK) disable iff (RST)
        !control_three[7] |-> channel[0].target == gain_code[1])
        else $error("Independent gain wrong.");

    a_flags_kept: assert property (@(posedge CLK) disable iff (RST)
        !(RD && ADDR == OVERFLOW_STATUS_OFFSET)
        |=> (channel_overflow_flags & $past(channel_overflow_flags)) == $past(channel_overflow_flags))
        else $error("Overflow flag dropped without a read.");

    a_detect_sets: assert property (@(posedge CLK) disable iff (RST)
        (OVERFLOW_DETECT != 6'h00)
        |=> (channel_overflow_flags & $past(OVERFLOW_DETECT)) == $past(OVERFLOW_DETECT))
        else $error("Overflow not recorded.");

    a_clear_keeps_new: assert property (@(posedge CLK) disable iff (RST)
        s_clearing_read |=> channel_overflow_flags == $past(OVERFLOW_DETECT))
        else $error("Clearing read left wrong flags.");

    a_status_upper_zero: assert property (@(posedge CLK) disable iff (RST)
        s_clearing_read |=> RDATA[7:6] == 2'b00)
        else $error("Unused status bits read as one.");

    a_rdata_idle: assert property (@(posedge CLK) disable iff (RST)
        !RD |=> RDATA == 8'h00)
        else $error("Read data stood without a read.");

    a_status_write_regs: assert property (@(posedge CLK) disable iff (RST)
        s_status_write |=> control_three == $past(control_three) && irq_mask == $past(irq_mask))
        else $error("Status write changed a register.");

    a_control_write: assert property (@(posedge CLK) disable iff (RST)
        s_control_write |=> control_three == ($past(WDATA) & CONTROL_THREE_MASK))
        else $error("Control write did not land.");

    a_pin_idle: assert property (@(posedge CLK) disable iff (RST)
        (channel_overflow_flags == 6'h00) |-> OVERFLOW_PIN == control_three[PIN_POLARITY_BIT])
        else $error("Idle overflow pin level wrong.");

    a_ramp_fast: assert property (@(posedge CLK) disable iff (RST)
        (!ADC_SAMPLE_RATE_MODE && !control_three[RAMP_SPEED_BIT]) |-> ramp_samples == 14'h0800)
        else $error("Fast ramp length wrong.");

    a_ramp_slow: assert property (@(posedge CLK) disable iff (RST)
        (!ADC_SAMPLE_RATE_MODE && control_three[RAMP_SPEED_BIT]) |-> ramp_samples == 14'h1000)
        else $error("Slow ramp length wrong.");

    a_ramp_dual_slow: assert property (@(posedge CLK) disable iff (RST)
        (ADC_SAMPLE_RATE_MODE && control_three[RAMP_SPEED_BIT]) |-> ramp_samples == 14'h2000)
        else $error("Dual rate slow ramp length wrong.");
endmodule : adc_overflow_gain_ctrl

// ===== hdl/gain_combiner.sv
// Combines the master and preset gain codes of one channel.
// Assumes codes in half-decibel steps with 215 as unity.
`timescale 1ns/100ps
module gain_combiner
    import adc_ctrl_pkg::*;
(
    // Mode and codes.
    input wire logic mode_select,
    input wire logic [7:0] master_code,
    input wire logic [7:0] preset_code,
    // Effective code.
    output logic [7:0] effective_code
);
    logic [9:0] sum;

    always_comb begin
        sum = {2'b00, master_code} + {2'b00, preset_code};
        effective_code = preset_code;
        if (mode_select) begin
            if (master_code <= GAIN_MUTE_LAST || preset_code <= GAIN_MUTE_LAST) begin
                effective_code = 8'h00;
            end else if (sum < {2'b00, GAIN_UNITY_CODE} + 10'h00f) begin
                effective_code = 8'h00;
            end else if (sum - {2'b00, GAIN_UNITY_CODE} > {2'b00, GAIN_MAX_CODE}) begin
                effective_code = GAIN_MAX_CODE;
            end else begin
                effective_code = 8'(sum - {2'b00, GAIN_UNITY_CODE});
            end
        end
    end
endmodule : gain_combiner

// ===== hdl/gain_ramp.sv
// Ramps one channel's applied level toward its target code.
// Assumes a one-cycle sample enable at the sample rate.
`timescale 1ns/100ps
module gain_ramp
    import adc_ctrl_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic sample_tick,
    input wire logic [13:0] ramp_samples,
    input wire logic [7:0] target_code,
    output logic [7:0] level,
    output logic busy
);
    logic [7:0] pending;
    logic [7:0] next_pending;
    logic [7:0] goal;
    logic [7:0] next_goal;
    logic [7:0] next_level;
    logic [13:0] count;
    logic [13:0] next_count;
    logic next_busy;

    always_comb begin
        next_pending = pending;
        next_goal = goal;
        next_level = level;
        next_count = count;
        next_busy = busy;
        if (target_code != pending) begin
            next_pending = target_code;
        end
        // A command written mid-ramp waits until this ramp has reached its own goal.
        if (!busy && next_pending != level) begin
            next_busy = 1'b1;
            next_count = ramp_samples;
            next_goal = next_pending;
        end else if (busy && sample_tick) begin
            if (count <= 14'h0001) begin
                next_busy = 1'b0;
                next_level = goal;
            end else begin
                next_count = count - 14'h0001;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pending <= GAIN_LEVEL_RESET;
            goal <= GAIN_LEVEL_RESET;
            level <= GAIN_LEVEL_RESET;
            count <= 14'h0000;
            busy <= 1'b0;
        end else begin
            pending <= next_pending;
            goal <= next_goal;
            level <= next_level;
            count <= next_count;
            busy <= next_busy;
        end
    end
endmodule : gain_ramp

// ===== tb/adc_overflow_gain_ctrl_tb_top.sv
// Testbench for the ADC overflow and gain control register bank.
// Assumes the package is compiled first; this bench drives every port itself.
`timescale 1ns/100ps
module adc_overflow_gain_ctrl_tb_top
    import adc_ctrl_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic write_en = 1'b0;
    logic read_en = 1'b0;
    logic tick = 1'b0;
    logic rate = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic [5:0] ovf = 6'h00;
    logic [7:0] rdata;
    logic [47:0] level;
    logic [5:0] busy;
    logic pin;
    logic irq;
    int bad_count = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [7:0] ctl_tab [4] = '{8'h00, 8'h40, 8'h00, 8'h40};
    int len_tab [4] = '{2048, 4096, 4096, 8192};

    adc_overflow_gain_ctrl #(.NUM_CHANNELS(6)) adc_overflow_gain_ctrl_inst (
        .CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(write_en), .RD(read_en),
        .RDATA(rdata), .OVERFLOW_DETECT(ovf), .SAMPLE_TICK(tick), .ADC_SAMPLE_RATE_MODE(rate),
        .ADC_CHANNEL_GAIN_LEVEL(level), .RAMP_BUSY(busy), .OVERFLOW_PIN(pin), .IRQ(irq)
    );

    always #25 clk = ~clk;

    // One sample period is two clock cycles; the run is cut off if it hangs.
    always @(posedge clk) begin
        tick <= ~tick;
        cycles <= cycles + 1;
        if (cycles == 80000) begin
            bad_count++;
            wrap_up();
        end
    end

    task chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t value %h expected %h", $time, got, exp);
        end
    endtask : chk

    task chk_len(input int got, input int exp);
        comparisons++;
        if (got < exp - 8 || got > exp + 8) begin
            bad_count++;
            $display("[ERR] %0t ramp took %0d cycles expected %0d", $time, got, exp);
        end
    endtask : chk_len

    task reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        write_en <= 1'b1;
        @(posedge clk);
        write_en <= 1'b0;
        #1;
    endtask : reg_write

    // A read may carry an overflow pulse in the same cycle as its strobe.
    task reg_read(input logic [7:0] a, input logic [7:0] exp, input logic [5:0] v);
        @(posedge clk);
        addr <= a;
        read_en <= 1'b1;
        ovf <= v;
        @(posedge clk);
        read_en <= 1'b0;
        ovf <= 6'h00;
        #1;
        chk(rdata, exp);
    endtask : reg_read

    task pulse(input logic [5:0] v);
        @(posedge clk);
        ovf <= v;
        @(posedge clk);
        ovf <= 6'h00;
        #1;
    endtask : pulse

    task ramp_wait(input int ch, input int exp, input logic [7:0] tgt);
        int n;
        n = 1;
        @(posedge clk);
        #1;
        while (busy[ch] !== 1'b0 && n < 20000) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk_len(n, exp);
        chk(level[8*ch +: 8], tgt);
    endtask : ramp_wait

    task wrap_up();
        $display("errors %0d comparisons %0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : wrap_up

    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        reg_read(8'h57, 8'h00, 6'h00);
        reg_read(8'h56, 8'h00, 6'h00);
        chk(level[15:8], GAIN_LEVEL_RESET);
        chk({7'h00, pin}, 8'h00);
        pulse(6'h21);
        pulse(6'h04);
        chk({7'h00, pin}, 8'h01);
        reg_write(8'h56, 8'hff);
        reg_read(8'h56, 8'h25, 6'h00);
        reg_read(8'h56, 8'h00, 6'h02);
        reg_read(8'h56, 8'h02, 6'h00);
        reg_read(8'h70, 8'h00, 6'h00);
        pulse(6'h01);
        reg_write(8'h57, 8'h01);
        chk({7'h00, pin}, 8'h00);
        reg_read(8'h57, 8'h01, 6'h00);
        reg_read(8'h56, 8'h01, 6'h00);
        chk({7'h00, pin}, 8'h01);
        reg_write(8'h60, 8'h01);
        pulse(6'h02);
        chk({7'h00, irq}, 8'h00);
        pulse(6'h01);
        chk({7'h00, irq}, 8'h01);
        reg_read(8'h56, 8'h03, 6'h00);
        chk({7'h00, irq}, 8'h00);
        for (int i = 0; i < 4; i++) begin
            rate <= (i >= 2);
            reg_write(8'h57, ctl_tab[i]);
            reg_write(8'h59, 8'(8'he0 + i));
            ramp_wait(0, 2 * len_tab[i], 8'(8'he0 + i));
        end
        rate <= 1'b0;
        reg_write(8'h57, 8'h00);
        reg_write(8'h5b, 8'h20);
        reg_write(8'h5b, 8'h30);
        reg_write(8'h5b, 8'h40);
        repeat (4150) @(posedge clk);
        #1;
        chk(level[23:16], 8'h20);
        repeat (4150) @(posedge clk);
        #1;
        chk(level[23:16], 8'h40);
        chk({2'b00, busy}, 8'h00);
        reg_write(8'h5a, 8'hf5);
        ramp_wait(1, 4096, 8'hf5);
        reg_write(8'h58, 8'he5);
        repeat (4) @(posedge clk);
        #1;
        chk({2'b00, busy}, 8'h00);
        chk(level[15:8], 8'hf5);
        reg_write(8'h57, 8'h80);
        ramp_wait(1, 4096, 8'hff);
        chk(level[31:24], 8'he5);
        chk(level[23:16], 8'h4e);
        chk(level[7:0], 8'hf1);
        chk(level[39:32], 8'he5);
        chk(level[47:40], 8'he5);
        wrap_up();
    end
endmodule : adc_overflow_gain_ctrl_tb_top
